/* core/uart_flags_regs.svh */
`ifndef UART_FLAGS_REGS_SVH
`define UART_FLAGS_REGS_SVH

// Byte offsets on the register bus
`define OFS_STATUS 8'h00
`define OFS_RX_DATA 8'h04
`define OFS_TX_DATA 8'h08
`define OFS_IRQ_STATUS 8'h0c
`define OFS_IRQ_CLEAR 8'h10
`define OFS_IRQ_ENABLE 8'h14

// Status register fields
`define ST_PARITY_BIT 0
`define ST_FRAMING_BIT 1
`define ST_OVERRUN_BIT 2
`define ST_RX_FULL_BIT 3
`define ST_TX_BUSY_BIT 4
`define ST_TX_FULL_BIT 5

// Interrupt status, clear and enable fields
`define IRQ_RX_BIT 0
`define IRQ_TX_BIT 1
`define IRQ_COUNT 2

// Reset values
`define RST_BYTE 8'h00
`define RST_RX_FLAGS 4'h0
`define RST_IRQ 2'h0

`endif

/* core/uart_flags_pkg.sv */
`default_nettype none

package uart_flags_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [31:0] word_t;

    // Receive flags in status register order
    typedef struct packed {
        logic rx_full;
        logic overrun;
        logic framing;
        logic parity;
    } rx_flags_t;
endpackage : uart_flags_pkg

`default_nettype wire

/* core/rx_side_if.sv */
`default_nettype none

interface rx_side_if;
    logic frame_done;
    uart_flags_pkg::byte_t frame_data;
    logic parity_bad;
    logic stop_bad;
    logic status_rd;
    logic data_rd;
    uart_flags_pkg::rx_flags_t flags;
    uart_flags_pkg::byte_t buf_data;
    logic rx_req;

    modport unit (
        input frame_done, frame_data, parity_bad, stop_bad, status_rd, data_rd,
        output flags, buf_data, rx_req
    );
    modport host (
        output frame_done, frame_data, parity_bad, stop_bad, status_rd, data_rd,
        input flags, buf_data, rx_req
    );
endinterface : rx_side_if

`default_nettype wire

/* core/rx_flag_unit.sv */
`default_nettype none
`include "uart_flags_regs.svh"

module rx_flag_unit (
    input wire logic clk_i,
    input wire logic rst_i,
    rx_side_if.unit rx
);
    uart_flags_pkg::rx_flags_t flags_r;
    uart_flags_pkg::rx_flags_t seen_r;
    uart_flags_pkg::byte_t buf_r;
    logic req_r;
    logic overrun;

    assign overrun = flags_r.rx_full | flags_r.overrun;
    assign rx.flags = flags_r;
    assign rx.buf_data = buf_r;
    assign rx.rx_req = req_r;

    // Snapshot of flags that were 1 at the last status read
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seen_r <= `RST_RX_FLAGS;
        end else if (rx.status_rd) begin
            seen_r <= flags_r;
        end else if (rx.data_rd) begin
            seen_r <= `RST_RX_FLAGS;
        end
    end

    // Clear first, then events; a set in the same cycle wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_r <= `RST_RX_FLAGS;
        end else begin
            if (rx.data_rd) begin
                flags_r <= flags_r & ~seen_r;
            end
            if (rx.frame_done) begin
                if (overrun) begin
                    flags_r.overrun <= 1'b1;
                end else begin
                    flags_r.rx_full <= 1'b1;
                    flags_r.parity <= rx.parity_bad;
                    flags_r.framing <= rx.stop_bad;
                end
            end
        end
    end

    // Buffer keeps the older byte on overrun; read value after a parity clear is not meaningful
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            buf_r <= `RST_BYTE;
        end else if (rx.frame_done && !overrun) begin
            buf_r <= rx.frame_data;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            req_r <= 1'b0;
        end else begin
            req_r <= rx.frame_done & ~flags_r.overrun;
        end
    end
endmodule : rx_flag_unit

`default_nettype wire

/* core/tx_flag_unit.sv */
`default_nettype none
`include "uart_flags_regs.svh"

module tx_flag_unit (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wr_i,
    input wire uart_flags_pkg::byte_t wr_data_i,
    input wire logic shift_done_i,
    output logic buf_full_o,
    output logic busy_o,
    output logic load_o,
    output uart_flags_pkg::byte_t load_data_o,
    output logic tx_req_o
);
    uart_flags_pkg::byte_t hold_r;
    logic full_r;
    logic busy_r;
    logic start;

    // Held byte moves into the shifter when it is idle or just finishing
    assign start = full_r & (~busy_r | shift_done_i);
    assign buf_full_o = full_r;
    assign busy_o = busy_r;

    // A late write overwrites the waiting byte
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_r <= `RST_BYTE;
        end else if (wr_i) begin
            hold_r <= wr_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            full_r <= 1'b0;
        end else if (wr_i) begin
            full_r <= 1'b1;
        end else if (start) begin
            full_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_r <= 1'b0;
        end else if (start) begin
            busy_r <= 1'b1;
        end else if (shift_done_i && !full_r) begin
            busy_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            load_o <= 1'b0;
            load_data_o <= `RST_BYTE;
            tx_req_o <= 1'b0;
        end else begin
            load_o <= start;
            tx_req_o <= start;
            if (start) begin
                load_data_o <= hold_r;
            end
        end
    end
endmodule : tx_flag_unit

`default_nettype wire

/* core/uart_status_flags.sv */
// Notes on behaviour
// - Parity mismatch on a received byte sets the parity flag and a receive request.
// - Zero sampled as stop bit sets the framing flag and a receive request.
// - New frame while previous byte is unread sets overrun flag and receive request.
// - On overrun the new frame is dropped; the buffered byte stays.
// - While overrun is set, further frames are dropped with no receive request.
// - Dropped frames never set the parity or framing flags.
// - Loading a received byte into the buffer sets the buffer full flag.
// - Data read clears only receive flags seen as 1 by a prior status read.
// - Flags set after the status read survive the next data read.
// - Data read that clears a parity error returns an undefined value.
// - Transmission ending with no byte waiting clears the busy flag.
// - Transmission restart after a buffer write sets busy and a transmit request.
// - Byte moving to the shifter clears buffer full and raises a transmit request.
// - Software write to the transmit buffer sets the buffer full flag.
// - After the stop bit the data bits load the buffer, flag full, request.
`default_nettype none
`include "uart_flags_regs.svh"

module uart_status_flags (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic rx_frame_done_i,
    input wire logic [7:0] rx_frame_data_i,
    input wire logic rx_parity_bad_i,
    input wire logic rx_stop_bad_i,
    input wire logic tx_shift_done_i,
    output logic tx_load_o,
    output logic [7:0] tx_load_data_o,
    output logic rx_req_o,
    output logic tx_req_o,
    output logic irq_o
);
    rx_side_if rx ();
    logic ack_r;
    uart_flags_pkg::word_t dat_r;
    logic req;
    logic acc;
    logic tx_wr;
    logic tx_full;
    logic tx_busy;
    logic tx_req;
    logic [`IRQ_COUNT-1:0] irq_ev;
    logic [`IRQ_COUNT-1:0] irq_st_r;
    logic [`IRQ_COUNT-1:0] irq_en_r;
    logic [`IRQ_COUNT-1:0] irq_clr;
    logic [5:0] status;

    function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
        hit = (adr[7:2] == ofs[7:2]);
    endfunction : hit

    // One wait state: ack rises the cycle after the request and drops after one cycle
    assign req = cyc_i & stb_i;
    assign acc = req & ack_r;
    assign ack_o = ack_r;
    assign dat_o = dat_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    assign status = {tx_full, tx_busy, rx.flags.rx_full, rx.flags.overrun,
                     rx.flags.framing, rx.flags.parity};

    // Read data is latched when the request is first seen, so it is stable under ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_r <= 32'h0000_0000;
        end else if (req && !ack_r && !we_i) begin
            dat_r <= 32'h0000_0000;
            if (hit(adr_i, `OFS_STATUS)) begin
                dat_r[5:0] <= status;
            end else if (hit(adr_i, `OFS_RX_DATA)) begin
                dat_r[7:0] <= rx.buf_data;
            end else if (hit(adr_i, `OFS_IRQ_STATUS)) begin
                dat_r[`IRQ_COUNT-1:0] <= irq_st_r;
            end else if (hit(adr_i, `OFS_IRQ_ENABLE)) begin
                dat_r[`IRQ_COUNT-1:0] <= irq_en_r;
            end
        end
    end

    // Snapshot shares the edge that latches read data, so a flag set under ack stays
    assign rx.status_rd = req & ~ack_r & ~we_i & hit(adr_i, `OFS_STATUS);
    assign rx.data_rd = acc & ~we_i & hit(adr_i, `OFS_RX_DATA);
    assign tx_wr = acc & we_i & sel_i[0] & hit(adr_i, `OFS_TX_DATA);
    assign irq_clr = (acc & we_i & sel_i[0] & hit(adr_i, `OFS_IRQ_CLEAR)) ?
                     dat_i[`IRQ_COUNT-1:0] : `RST_IRQ;

    assign rx.frame_done = rx_frame_done_i;
    assign rx.frame_data = rx_frame_data_i;
    assign rx.parity_bad = rx_parity_bad_i;
    assign rx.stop_bad = rx_stop_bad_i;

    rx_flag_unit u_rx (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .rx(rx.unit)
    );

    tx_flag_unit u_tx (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_i(tx_wr),
        .wr_data_i(dat_i[7:0]),
        .shift_done_i(tx_shift_done_i),
        .buf_full_o(tx_full),
        .busy_o(tx_busy),
        .load_o(tx_load_o),
        .load_data_o(tx_load_data_o),
        .tx_req_o(tx_req)
    );

    assign rx_req_o = rx.rx_req;
    assign tx_req_o = tx_req;
    assign irq_ev[`IRQ_RX_BIT] = rx.rx_req;
    assign irq_ev[`IRQ_TX_BIT] = tx_req;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_en_r <= `RST_IRQ;
        end else if (acc && we_i && sel_i[0] && hit(adr_i, `OFS_IRQ_ENABLE)) begin
            irq_en_r <= dat_i[`IRQ_COUNT-1:0];
        end
    end

    // Sticky bits; a new event beats a clear in the same cycle
    generate
        for (genvar i = 0; i < `IRQ_COUNT; i++) begin : g_irq
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    irq_st_r[i] <= 1'b0;
                end else if (irq_ev[i]) begin
                    irq_st_r[i] <= 1'b1;
                end else if (irq_clr[i]) begin
                    irq_st_r[i] <= 1'b0;
                end
            end
        end
    endgenerate

    assign irq_o = |(irq_st_r & irq_en_r);
endmodule : uart_status_flags

`default_nettype wire

/* testbench/uart_status_flags_assertions.sv */
`default_nettype none
module uart_status_flags_assertions (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic rx_frame_done_i,
    input wire logic tx_shift_done_i,
    input wire logic tx_load_o,
    input wire logic [7:0] tx_load_data_o,
    input wire logic rx_req_o,
    input wire logic tx_req_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic txw;
    assign txw = ack_o && we_i && adr_i == 8'h08;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    ack_once_a: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    ack_resp_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not acknowledged");
    reset_quiet_a: assert property ($fell(rst_i) |-> !ack_o && !rx_req_o && !tx_load_o && dat_o == 0)
        else $error("outputs active after reset");
    rx_req_src_a: assert property (rx_req_o |-> $past(rx_frame_done_i))
        else $error("receive request without frame");
    tx_load_src_a: assert property (tx_load_o |-> $past(tx_shift_done_i) || $past(txw, 2))
        else $error("load without write or done");
    tx_pair_a: assert property (tx_load_o |-> tx_req_o)
        else $error("load without transmit request");
    load_pulse_a: assert property (tx_load_o |=> !tx_load_o)
        else $error("load longer than one cycle");
    tx_data_hold_a: assert property ($changed(tx_load_data_o) |-> tx_load_o)
        else $error("shifter byte moved without load");
    cover property (rx_req_o);
    cover property (tx_load_o && tx_req_o);
    cover property (txw);
endmodule : uart_status_flags_assertions

bind uart_status_flags uart_status_flags_assertions u_chk (.clk_i, .rst_i, .cyc_i, .stb_i,
    .we_i, .adr_i, .dat_o, .ack_o, .rx_frame_done_i, .tx_shift_done_i, .tx_load_o,
    .tx_load_data_o, .rx_req_o, .tx_req_o);
`default_nettype wire

/* testbench/serial_node_model.sv */
`default_nettype none
module serial_node_model (
    input wire logic clk_i,
    input wire logic tx_load_i,
    output logic tx_shift_done_o,
    output logic rx_frame_done_o,
    output logic [7:0] rx_frame_data_o,
    output logic rx_parity_bad_o,
    output logic rx_stop_bad_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int gap = 3;
    int cnt = 0;
    initial begin
        tx_shift_done_o = 1'b0;
        rx_frame_done_o = 1'b0;
        rx_frame_data_o = 8'h00;
        rx_parity_bad_o = 1'b0;
        rx_stop_bad_o = 1'b0;
    end
    // Done comes only after a load, gap cycles later
    always @(posedge clk_i) begin
        tx_shift_done_o <= (cnt == 1);
        cnt <= tx_load_i ? gap : (cnt > 0 ? cnt - 1 : 0);
    end
    task automatic send(input logic [7:0] d, input logic p, input logic s);
        @(posedge clk_i);
        rx_frame_done_o <= 1'b1;
        rx_frame_data_o <= d;
        rx_parity_bad_o <= p;
        rx_stop_bad_o <= s;
        @(posedge clk_i);
        // Lines outside the pulse carry junk so stale values are never trusted
        rx_frame_done_o <= 1'b0;
        rx_frame_data_o <= ~d;
        rx_parity_bad_o <= ~p;
        rx_stop_bad_o <= ~s;
    endtask : send
endmodule : serial_node_model
`default_nettype wire

/* testbench/tb.sv */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o, rd;
    logic ack_o, fd, pb, sb, sd, ld, rq, tq, irq_o;
    logic [7:0] fdat, ldat, b_m;
    logic [7:0] lfsr_r = 8'h60;
    logic [3:0] f_m = 4'h0;
    logic [3:0] snap_m = 4'h0;
    int num_errors = 0;
    int num_checks = 0;
    always #4 clk_i = ~clk_i;
    uart_status_flags u_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i(4'h1),
        .dat_i, .dat_o, .ack_o, .rx_frame_done_i(fd), .rx_frame_data_i(fdat),
        .rx_parity_bad_i(pb), .rx_stop_bad_i(sb), .tx_shift_done_i(sd), .tx_load_o(ld),
        .tx_load_data_o(ldat), .rx_req_o(rq), .tx_req_o(tq), .irq_o);
    serial_node_model u_node (.clk_i, .tx_load_i(ld), .tx_shift_done_o(sd),
        .rx_frame_done_o(fd), .rx_frame_data_o(fdat), .rx_parity_bad_o(pb), .rx_stop_bad_o(sb));
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1 && ++n < 50);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (n >= 50) num_errors++;
    endtask : wb
    task automatic wait_ld;
        int n;
        n = 0;
        do @(posedge clk_i); while (ld !== 1'b1 && ++n < 200);
        if (n >= 200) num_errors++;
    endtask : wait_ld
    task automatic frame(input logic [7:0] d, input logic p, input logic s);
        logic req;
        req = !f_m[2];
        u_node.send(d, p, s);
        if (f_m[3] || f_m[2]) f_m[2] = 1'b1;
        else begin
            b_m = d;
            f_m = {1'b1, 1'b0, s, p};
        end
        #1 chk(32'(rq), 32'(req));
    endtask : frame
    task automatic rdst;
        wb(1'b0, 8'h00, 32'h0);
        chk(32'(rd[3:0]), 32'(f_m));
        snap_m = f_m;
    endtask : rdst
    task automatic rddat;
        wb(1'b0, 8'h04, 32'h0);
        // Value after a parity clear is undefined, so it is left alone
        if (snap_m[3] && !snap_m[0]) chk(32'(rd[7:0]), 32'(b_m));
        f_m = f_m & ~snap_m;
        snap_m = 4'h0;
    endtask : rddat
    task automatic give_verdict;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : give_verdict
    initial begin
        #100000;
        num_errors++;
        give_verdict();
    end
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rdst();
        wb(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        $display("end reset");
        for (int i = 0; i < 4; i++) begin
            frame(8'h5a + 8'(i), i[0], i[1]);
            rdst();
            rddat();
        end
        frame(8'ha1, 1'b0, 1'b0);
        frame(8'hb2, 1'b0, 1'b0);
        frame(8'hc3, 1'b1, 1'b1);
        rdst();
        rddat();
        frame(8'hd4, 1'b0, 1'b0);
        rdst();
        frame(8'he5, 1'b1, 1'b0);
        rddat();
        rdst();
        rddat();
        frame(8'h11, 1'b1, 1'b1);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        f_m = 4'h0;
        snap_m = 4'h0;
        rdst();
        $display("end receive");
        repeat (16) begin
            lfsr_r = lfsr(lfsr_r);
            frame(lfsr_r, lfsr_r[0] & lfsr_r[3], lfsr_r[1] & lfsr_r[4]);
            if (lfsr_r[5]) rdst();
            if (lfsr_r[6]) rddat();
        end
        $display("end random");
        wb(1'b0, 8'h0c, 32'h0);
        chk(rd, 32'h1);
        wb(1'b1, 8'h14, 32'h3);
        #1 chk(32'(irq_o), 32'h1);
        wb(1'b1, 8'h10, 32'h3);
        #1 chk(32'(irq_o), 32'h0);
        u_node.gap = 40;
        wb(1'b1, 8'h08, 32'h3c);
        wait_ld();
        chk(32'(ldat), 32'h3c);
        chk(32'(tq), 32'h1);
        wb(1'b1, 8'h08, 32'h7e);
        wb(1'b0, 8'h00, 32'h0);
        chk(32'(rd[5:4]), 32'h3);
        wait_ld();
        chk(32'(ldat), 32'h7e);
        repeat (60) @(posedge clk_i);
        wb(1'b0, 8'h00, 32'h0);
        chk(32'(rd[5:4]), 32'h0);
        chk(32'(irq_o), 32'h1);
        wb(1'b1, 8'h14, 32'h0);
        #1 chk(32'(irq_o), 32'h0);
        $display("end transmit");
        give_verdict();
    end
endmodule : tb
`default_nettype wire
